// file: rtl/spo_pkg.sv
// Purpose: Constants for the second PLL output configuration block
// Assumes: Byte-wide registers at their printed offsets, plain register port
// Notes:   Rule summary follows
// Contract
// - Down-spread codes 001..111 give 0.25..2.0 percent downward modulation.
// - Center-spread uses same codes as symmetric plus/minus modulation.
// - Spread code 000 turns modulation off in both modes.
// - Frequency select bit 0 picks parameter set a, 1 picks set b.
// - Bypass bit 1 bypasses and powers down the second PLL.
// - Fourth output from second divider on 0, fourth divider on 1.
// - Fifth output from divider two, four, five on 00, 01, 10.
// - State 00 tristates both outputs and powers down the PLL.
// - State 01 tristates both outputs, PLL keeps running.
// - State 10 drives both outputs low, PLL keeps running.
// - State 11 enables both outputs normally, PLL running.
// - Per-setting state select 0 applies the state0 definition.
// - Per-setting state select 1 applies the state1 definition.
// - Eight settings, active one chosen by three control pins.
// - Spread direction 0 is down-spread, 1 is center-spread.
package spo_pkg;
  localparam logic [7:0] SPO_OFS_SPREAD_HIGH = 8'h20;
  localparam logic [7:0] SPO_OFS_SPREAD_MID  = 8'h21;
  localparam logic [7:0] SPO_OFS_SPREAD_LOW  = 8'h22;
  localparam logic [7:0] SPO_OFS_FREQ_SEL    = 8'h23;
  localparam logic [7:0] SPO_OFS_MUX_STATE   = 8'h24;
  localparam logic [7:0] SPO_OFS_STATE_SEL   = 8'h25;
  localparam logic [7:0] SPO_OFS_DIRECTION   = 8'h26;

  localparam logic [7:0] SPO_RST_SPREAD_HIGH = 8'h00;
  localparam logic [7:0] SPO_RST_SPREAD_MID  = 8'h00;
  localparam logic [7:0] SPO_RST_SPREAD_LOW  = 8'h00;
  localparam logic [7:0] SPO_RST_FREQ_SEL    = 8'h00;
  localparam logic [7:0] SPO_RST_MUX_STATE   = 8'hed;
  localparam logic [7:0] SPO_RST_STATE_SEL   = 8'h02;
  localparam logic [7:0] SPO_RST_DIRECTION   = 8'h00;

  localparam int SPO_BIT_BYPASS    = 7;
  localparam int SPO_BIT_Y4_SRC    = 6;
  localparam int SPO_POS_Y5_SRC    = 4;
  localparam int SPO_POS_STATE1    = 2;
  localparam int SPO_POS_STATE0    = 0;
  localparam int SPO_BIT_DIRECTION = 7;

  localparam logic [1:0] SPO_ST_OFF_PD  = 2'h0;
  localparam logic [1:0] SPO_ST_HIZ     = 2'h1;
  localparam logic [1:0] SPO_ST_LOW     = 2'h2;
  localparam logic [1:0] SPO_ST_ENABLED = 2'h3;

  localparam logic [1:0] SPO_SRC_DIV2 = 2'h0;
  localparam logic [1:0] SPO_SRC_DIV4 = 2'h1;
  localparam logic [1:0] SPO_SRC_DIV5 = 2'h2;

  // Spread amount in hundredths of a percent
  localparam logic [7:0] SPO_AMT_025 = 8'h19;
  localparam logic [7:0] SPO_AMT_050 = 8'h32;
  localparam logic [7:0] SPO_AMT_075 = 8'h4b;
  localparam logic [7:0] SPO_AMT_100 = 8'h64;
  localparam logic [7:0] SPO_AMT_125 = 8'h7d;
  localparam logic [7:0] SPO_AMT_150 = 8'h96;
  localparam logic [7:0] SPO_AMT_200 = 8'hc8;
endpackage : spo_pkg

// file: rtl/spo_second_pll_output_config.sv
// Purpose: Register file and per-setting decode for the second PLL and outputs four/five
// Assumes: Settings pins are asynchronous; register port is on clk
// Notes:   All outputs registered; one cycle latency from register to output, five cycles from setting pin to output
`timescale 1ns/100ps
module spo_second_pll_output_config (
  // Clock and reset
  input  wire  logic       clk,
  input  wire  logic       rst,
  input  wire  logic       clk_en,
  // Register port
  input  wire  logic [7:0] reg_addr,
  input  wire  logic [7:0] reg_wdata,
  input  wire  logic       reg_wr,
  input  wire  logic       reg_rd,
  output logic       [7:0] reg_rdata,
  // Setting pins
  input  wire  logic       setting_pin_zero,
  input  wire  logic       setting_pin_one,
  input  wire  logic       setting_pin_two,
  // Second PLL control
  output logic       [2:0] active_setting,
  output logic             second_pll_freq_select,
  output logic             second_pll_param_set_b,
  output logic             second_pll_bypass_select,
  output logic             second_pll_power_down,
  output logic             spread_enable,
  output logic             second_pll_spread_direction,
  output logic       [7:0] spread_amount,
  // Output pair control
  output logic             fourth_output_source_select,
  output logic       [1:0] fifth_output_source_select,
  output logic       [1:0] output_pair_state,
  output logic             output_pair_oe_n,
  output logic             output_pair_force_low,
  output logic             output_pair_clock_enable
);
  import spo_pkg::*;

  typedef struct packed {
    logic [7:0] spread_high;
    logic [7:0] spread_mid;
    logic [7:0] spread_low;
    logic [7:0] freq_sel;
    logic [7:0] mux_state;
    logic [7:0] state_sel;
    logic [7:0] direction;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] setting;
    logic [7:0] rdata;
    logic [2:0] act;
    logic       fsel;
    logic       bypass;
    logic       pdn;
    logic       ssc_en;
    logic       ssc_dir;
    logic [7:0] ssc_amt;
    logic       y4_src;
    logic [1:0] y5_src;
    logic [1:0] pstate;
    logic       oe_n;
    logic       force_low;
    logic       clk_on;
  } spo_state_t;

  spo_state_t st;
  spo_state_t next_st;

  function automatic logic [7:0] spo_amount(input logic [2:0] code);
    case (code)
      3'h1:    spo_amount = SPO_AMT_025;
      3'h2:    spo_amount = SPO_AMT_050;
      3'h3:    spo_amount = SPO_AMT_075;
      3'h4:    spo_amount = SPO_AMT_100;
      3'h5:    spo_amount = SPO_AMT_125;
      3'h6:    spo_amount = SPO_AMT_150;
      3'h7:    spo_amount = SPO_AMT_200;
      default: spo_amount = 8'h00;
    endcase
  endfunction : spo_amount

  function automatic logic [7:0] spo_read(input logic [7:0] a, input spo_state_t s);
    case (a)
      SPO_OFS_SPREAD_HIGH: spo_read = s.spread_high;
      SPO_OFS_SPREAD_MID:  spo_read = s.spread_mid;
      SPO_OFS_SPREAD_LOW:  spo_read = s.spread_low;
      SPO_OFS_FREQ_SEL:    spo_read = s.freq_sel;
      SPO_OFS_MUX_STATE:   spo_read = s.mux_state;
      SPO_OFS_STATE_SEL:   spo_read = s.state_sel;
      SPO_OFS_DIRECTION:   spo_read = s.direction;
      default:             spo_read = 8'h00;
    endcase
  endfunction : spo_read

  logic [23:0] spread_all;
  logic [2:0]  cur_code;
  logic [1:0]  cur_state;
  logic [2:0]  code_shift;
  logic        fsel_pick;
  logic [1:0]  state0_def;
  logic [1:0]  state1_def;

  always_comb begin
    next_st = st;
    spread_all = {st.spread_high, st.spread_mid, st.spread_low};
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        SPO_OFS_SPREAD_HIGH: next_st.spread_high = reg_wdata;
        SPO_OFS_SPREAD_MID:  next_st.spread_mid  = reg_wdata;
        SPO_OFS_SPREAD_LOW:  next_st.spread_low  = reg_wdata;
        SPO_OFS_FREQ_SEL:    next_st.freq_sel    = reg_wdata;
        SPO_OFS_MUX_STATE:   next_st.mux_state   = reg_wdata;
        SPO_OFS_STATE_SEL:   next_st.state_sel   = reg_wdata;
        SPO_OFS_DIRECTION:   next_st.direction   = reg_wdata;
        default: begin
        end
      endcase
    end
    next_st.rdata = reg_rd ? spo_read(reg_addr, st) : 8'h00;
    // Pin synchroniser, accept change once stages two and three agree
    next_st.pin_s1 = {setting_pin_two, setting_pin_one, setting_pin_zero};
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    if (st.pin_s2 == st.pin_s3) begin
      next_st.setting = st.pin_s3;
    end
    // Per-setting field selection
    code_shift = st.setting;
    cur_code = spread_all[3*code_shift +: 3];
    cur_state = st.state_sel[st.setting] ?
                st.mux_state[SPO_POS_STATE1 +: 2] :
                st.mux_state[SPO_POS_STATE0 +: 2];
    next_st.act     = st.setting;
    next_st.fsel    = st.freq_sel[st.setting];
    next_st.bypass  = st.mux_state[SPO_BIT_BYPASS];
    next_st.ssc_dir = st.direction[SPO_BIT_DIRECTION];
    next_st.ssc_en  = (cur_code != 3'h0);
    next_st.ssc_amt = spo_amount(cur_code);
    next_st.y4_src  = st.mux_state[SPO_BIT_Y4_SRC];
    next_st.y5_src  = st.mux_state[SPO_POS_Y5_SRC +: 2];
    next_st.pstate  = cur_state;
    // Power down by bypass or state 00
    next_st.pdn = st.mux_state[SPO_BIT_BYPASS] || (cur_state == SPO_ST_OFF_PD);
    case (cur_state)
      SPO_ST_OFF_PD: begin
        next_st.oe_n = 1'b1;
        next_st.force_low = 1'b0;
        next_st.clk_on = 1'b0;
      end
      SPO_ST_HIZ: begin
        next_st.oe_n = 1'b1;
        next_st.force_low = 1'b0;
        next_st.clk_on = 1'b0;
      end
      SPO_ST_LOW: begin
        next_st.oe_n = 1'b0;
        next_st.force_low = 1'b1;
        next_st.clk_on = 1'b0;
      end
      default: begin
        next_st.oe_n = 1'b0;
        next_st.force_low = 1'b0;
        next_st.clk_on = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.spread_high <= SPO_RST_SPREAD_HIGH;
      st.spread_mid  <= SPO_RST_SPREAD_MID;
      st.spread_low  <= SPO_RST_SPREAD_LOW;
      st.freq_sel    <= SPO_RST_FREQ_SEL;
      st.mux_state   <= SPO_RST_MUX_STATE;
      st.state_sel   <= SPO_RST_STATE_SEL;
      st.direction   <= SPO_RST_DIRECTION;
      st.bypass      <= 1'b1;
      st.pdn         <= 1'b1;
      st.oe_n        <= 1'b1;
      st.pstate      <= SPO_ST_HIZ;
      st.y4_src      <= 1'b1;
      st.y5_src      <= SPO_SRC_DIV5;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata                   = st.rdata;
  assign active_setting              = st.act;
  assign second_pll_freq_select      = st.fsel;
  assign second_pll_param_set_b      = st.fsel;
  assign second_pll_bypass_select    = st.bypass;
  assign second_pll_power_down       = st.pdn;
  assign spread_enable               = st.ssc_en;
  assign second_pll_spread_direction = st.ssc_dir;
  assign spread_amount               = st.ssc_amt;
  assign fourth_output_source_select = st.y4_src;
  assign fifth_output_source_select  = st.y5_src;
  assign output_pair_state           = st.pstate;
  assign output_pair_oe_n            = st.oe_n;
  assign output_pair_force_low       = st.force_low;
  assign output_pair_clock_enable    = st.clk_on;

  // Assertion helpers
  assign fsel_pick  = st.freq_sel[st.setting];
  assign state0_def = st.mux_state[SPO_POS_STATE0 +: 2];
  assign state1_def = st.mux_state[SPO_POS_STATE1 +: 2];

  property p_spread_off;
    @(posedge clk) disable iff (rst)
      (clk_en && spread_all[3*code_shift +: 3] == 3'h0) |=> (!spread_enable && spread_amount == 8'h00);
  endproperty
  a_spread_off: assert property (p_spread_off) else $error("spread not off for code 000");

  property p_amount;
    @(posedge clk) disable iff (rst)
      (clk_en && spread_all[3*code_shift +: 3] == 3'h7) |=> (spread_amount == 8'hc8);
  endproperty
  a_amount: assert property (p_amount) else $error("code 111 not 2.0 percent");

  property p_center_amt;
    @(posedge clk) disable iff (rst)
      (clk_en && st.direction[SPO_BIT_DIRECTION] && spread_all[3*code_shift +: 3] == 3'h1)
      |=> (second_pll_spread_direction && spread_amount == 8'h19);
  endproperty
  a_center_amt: assert property (p_center_amt) else $error("center 001 wrong");

  property p_bypass_pd;
    @(posedge clk) disable iff (rst)
      (clk_en && st.mux_state[SPO_BIT_BYPASS]) |=> second_pll_power_down;
  endproperty
  a_bypass_pd: assert property (p_bypass_pd) else $error("bypass without power down");

  property p_state_pd;
    @(posedge clk) disable iff (rst)
      (output_pair_state == 2'h0) |-> (second_pll_power_down && output_pair_oe_n);
  endproperty
  a_state_pd: assert property (p_state_pd) else $error("state 00 not off");

  property p_state_hiz;
    @(posedge clk) disable iff (rst)
      (output_pair_state == 2'h1) |-> (output_pair_oe_n && !output_pair_clock_enable);
  endproperty
  a_state_hiz: assert property (p_state_hiz) else $error("state 01 not tristate");

  property p_state_low;
    @(posedge clk) disable iff (rst)
      (output_pair_state == 2'h2) |-> (!output_pair_oe_n && output_pair_force_low);
  endproperty
  a_state_low: assert property (p_state_low) else $error("state 10 not low");

  property p_state_on;
    @(posedge clk) disable iff (rst)
      (output_pair_state == 2'h3) |-> (!output_pair_oe_n && output_pair_clock_enable
                                       && !output_pair_force_low);
  endproperty
  a_state_on: assert property (p_state_on) else $error("state 11 not enabled");

  property p_pin_settle;
    @(posedge clk) disable iff (rst)
      (clk_en [*4]) ##1 (clk_en && $stable(st.pin_s1) && $stable(st.pin_s2))
      |=> (st.setting == st.pin_s3);
  endproperty
  a_pin_settle: assert property (p_pin_settle) else $error("setting did not follow pins");

  property p_fsel;
    @(posedge clk) disable iff (rst)
      clk_en |=> (second_pll_freq_select == $past(fsel_pick));
  endproperty
  a_fsel: assert property (p_fsel) else $error("frequency select mismatch");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      !clk_en |=> $stable(st);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_y4_div4;
    @(posedge clk) disable iff (rst)
      (clk_en && st.mux_state[SPO_BIT_Y4_SRC]) |=> fourth_output_source_select;
  endproperty
  a_y4_div4: assert property (p_y4_div4) else $error("fourth source not divider four");

  property p_y4_div2;
    @(posedge clk) disable iff (rst)
      (clk_en && !st.mux_state[SPO_BIT_Y4_SRC]) |=> !fourth_output_source_select;
  endproperty
  a_y4_div2: assert property (p_y4_div2) else $error("fourth source not divider two");

  property p_y5_div2;
    @(posedge clk) disable iff (rst)
      (clk_en && st.mux_state[SPO_POS_Y5_SRC +: 2] == SPO_SRC_DIV2)
      |=> (fifth_output_source_select == SPO_SRC_DIV2);
  endproperty
  a_y5_div2: assert property (p_y5_div2) else $error("fifth source not divider two");

  property p_y5_div4;
    @(posedge clk) disable iff (rst)
      (clk_en && st.mux_state[SPO_POS_Y5_SRC +: 2] == SPO_SRC_DIV4)
      |=> (fifth_output_source_select == SPO_SRC_DIV4);
  endproperty
  a_y5_div4: assert property (p_y5_div4) else $error("fifth source not divider four");

  property p_y5_div5;
    @(posedge clk) disable iff (rst)
      (clk_en && st.mux_state[SPO_POS_Y5_SRC +: 2] == SPO_SRC_DIV5)
      |=> (fifth_output_source_select == SPO_SRC_DIV5);
  endproperty
  a_y5_div5: assert property (p_y5_div5) else $error("fifth source not divider five");

  property p_state0_pick;
    @(posedge clk) disable iff (rst)
      (clk_en && !st.state_sel[st.setting]) |=> (output_pair_state == $past(state0_def));
  endproperty
  a_state0_pick: assert property (p_state0_pick) else $error("state0 not applied");

  property p_state1_pick;
    @(posedge clk) disable iff (rst)
      (clk_en && st.state_sel[st.setting]) |=> (output_pair_state == $past(state1_def));
  endproperty
  a_state1_pick: assert property (p_state1_pick) else $error("state1 not applied");

  property p_down;
    @(posedge clk) disable iff (rst)
      (clk_en && !st.direction[SPO_BIT_DIRECTION]) |=> !second_pll_spread_direction;
  endproperty
  a_down: assert property (p_down) else $error("down-spread not selected");

  property p_amount_down;
    @(posedge clk) disable iff (rst)
      (clk_en && !st.direction[SPO_BIT_DIRECTION] && cur_code == 3'h1)
      |=> (!second_pll_spread_direction && spread_amount == SPO_AMT_025);
  endproperty
  a_amount_down: assert property (p_amount_down) else $error("down 001 wrong");

  property p_setting;
    @(posedge clk) disable iff (rst)
      clk_en |=> (active_setting == $past(st.setting));
  endproperty
  a_setting: assert property (p_setting) else $error("active setting mismatch");

  property p_spread_on;
    @(posedge clk) disable iff (rst)
      (clk_en && cur_code != 3'h0) |=> spread_enable;
  endproperty
  a_spread_on: assert property (p_spread_on) else $error("spread not on for nonzero code");

  property p_power_on;
    @(posedge clk) disable iff (rst)
      (clk_en && !st.mux_state[SPO_BIT_BYPASS] && cur_state != SPO_ST_OFF_PD)
      |=> !second_pll_power_down;
  endproperty
  a_power_on: assert property (p_power_on) else $error("PLL powered down without cause");

  property p_bypass_sel;
    @(posedge clk) disable iff (rst)
      (clk_en && st.mux_state[SPO_BIT_BYPASS]) |=> second_pll_bypass_select;
  endproperty
  a_bypass_sel: assert property (p_bypass_sel) else $error("bypass select not set");
endmodule : spo_second_pll_output_config

// file: testbench/tb_second_pll_output_config.sv
// Purpose: Self-checking bench for the second PLL output configuration block
// Assumes: Register port with read data in the cycle after the read strobe
// Notes:   Fixed settle counts follow the hand-over latencies
`timescale 1ns/100ps
module tb_second_pll_output_config;
  import spo_pkg::*;
  logic       clk, rst, clk_en, reg_wr, reg_rd, pin0, pin1, pin2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, spread_amount;
  logic [2:0] active_setting;
  logic       fsel, set_b, byp, pdn, spr_en, spr_dir, y4_src, oe_n, flow, cken;
  logic [1:0] y5_src, pair_state;
  int         n_errors, n_compared;
  logic [7:0] amt [8];
  logic [23:0] codes;
  localparam logic [7:0] FS_PAT = 8'ha5;

  spo_second_pll_output_config uut (
    .clk(clk), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .setting_pin_zero(pin0), .setting_pin_one(pin1), .setting_pin_two(pin2),
    .active_setting(active_setting), .second_pll_freq_select(fsel),
    .second_pll_param_set_b(set_b), .second_pll_bypass_select(byp),
    .second_pll_power_down(pdn), .spread_enable(spr_en),
    .second_pll_spread_direction(spr_dir), .spread_amount(spread_amount),
    .fourth_output_source_select(y4_src), .fifth_output_source_select(y5_src),
    .output_pair_state(pair_state), .output_pair_oe_n(oe_n),
    .output_pair_force_low(flow), .output_pair_clock_enable(cken)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic pins(input logic [2:0] s);
    @(posedge clk);
    {pin2, pin1, pin0} <= s;
    settle(6);
  endtask : pins

  // Expected pair controls from active state code and bypass bit
  task automatic chk_pair(input logic [1:0] st, input logic b);
    chk("pair state", {6'h0, st}, {6'h0, pair_state});
    chk("bypass", {7'h0, b}, {7'h0, byp});
    chk("pair ctrl", {4'h0, b | (st == SPO_ST_OFF_PD), st[1] == 1'b0, st == SPO_ST_LOW,
        st == SPO_ST_ENABLED}, {4'h0, pdn, oe_n, flow, cken});
  endtask : chk_pair

  task automatic final_report;
    $display("Counts: compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  initial begin
    amt = '{8'h00, SPO_AMT_025, SPO_AMT_050, SPO_AMT_075, SPO_AMT_100, SPO_AMT_125,
            SPO_AMT_150, SPO_AMT_200};
    n_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {pin2, pin1, pin0} = 3'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle(6);
    // Reset values, unmapped place, read back
    rd(SPO_OFS_SPREAD_HIGH, SPO_RST_SPREAD_HIGH);
    rd(SPO_OFS_SPREAD_MID, SPO_RST_SPREAD_MID);
    rd(SPO_OFS_SPREAD_LOW, SPO_RST_SPREAD_LOW);
    rd(SPO_OFS_FREQ_SEL, SPO_RST_FREQ_SEL);
    rd(SPO_OFS_MUX_STATE, SPO_RST_MUX_STATE);
    rd(SPO_OFS_STATE_SEL, SPO_RST_STATE_SEL);
    rd(SPO_OFS_DIRECTION, SPO_RST_DIRECTION);
    chk_pair(SPO_ST_HIZ, 1'b1);
    chk("sources", 8'h06, {5'h0, y4_src, y5_src});
    chk("spread off", 8'h00, spread_amount);
    chk("spread enable off", 8'h00, {7'h0, spr_en});
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    wr(SPO_OFS_FREQ_SEL, 8'h3c);
    rd(SPO_OFS_FREQ_SEL, 8'h3c);
    $display("test reset and access done");
    // Every spread code in both directions, setting zero
    for (int d = 0; d < 2; d++) begin
      wr(SPO_OFS_DIRECTION, {d[0], 7'h00});
      for (int c = 0; c < 8; c++) begin
        wr(SPO_OFS_SPREAD_LOW, {5'h0, c[2:0]});
        settle(3);
        chk("spread amount", amt[c], spread_amount);
        chk("spread enable", {7'h0, c != 0}, {7'h0, spr_en});
        chk("direction", {7'h0, d[0]}, {7'h0, spr_dir});
      end
    end
    $display("test spread codes done");
    // Distinct field per setting, walked through by the pins
    for (int n = 0; n < 8; n++) codes[3*n +: 3] = 3'(7 - n);
    wr(SPO_OFS_SPREAD_HIGH, codes[23:16]);
    wr(SPO_OFS_SPREAD_MID, codes[15:8]);
    wr(SPO_OFS_SPREAD_LOW, codes[7:0]);
    wr(SPO_OFS_FREQ_SEL, FS_PAT);
    wr(SPO_OFS_STATE_SEL, 8'h5a);
    wr(SPO_OFS_MUX_STATE, 8'h1e);
    for (int s = 0; s < 8; s++) begin
      pins(s[2:0]);
      chk("setting", {5'h0, s[2:0]}, {5'h0, active_setting});
      chk("spread amount", amt[7 - s], spread_amount);
      chk("freq select", {6'h0, {2{FS_PAT[s]}}}, {6'h0, fsel, set_b});
      chk_pair(((8'h5a >> s) & 8'h01) != 0 ? SPO_ST_ENABLED : SPO_ST_LOW, 1'b0);
      chk("sources", 8'h01, {5'h0, y4_src, y5_src});
    end
    $display("test settings done");
    // State definitions, bypass and sources, state0 active
    pins(3'h0);
    for (int b = 0; b < 2; b++) begin
      for (int st = 0; st < 4; st++) begin
        wr(SPO_OFS_MUX_STATE, {b[0], b[0], (st == 3) ? 2'b00 : 2'b10, 2'b00, st[1:0]});
        settle(3);
        chk_pair(st[1:0], b[0]);
        chk("sources", {5'h0, b[0], (st == 3) ? 2'b00 : 2'b10},
            {5'h0, y4_src, y5_src});
      end
    end
    $display("test state definitions done");
    // Clock enable low freezes registers, pins and outputs
    @(posedge clk);
    clk_en <= 1'b0;
    wr(SPO_OFS_SPREAD_LOW, 8'h00);
    pins(3'h5);
    chk("frozen setting", 8'h00, {5'h0, active_setting});
    chk("frozen amount", SPO_AMT_200, spread_amount);
    @(posedge clk);
    clk_en <= 1'b1;
    settle(6);
    chk("thawed setting", 8'h05, {5'h0, active_setting});
    chk("thawed amount", SPO_AMT_050, spread_amount);
    rd(SPO_OFS_SPREAD_LOW, codes[7:0]);
    $display("test clock enable done");
    // Reset in mid-run restores defaults
    rst <= 1'b1;
    settle(2);
    chk_pair(SPO_ST_HIZ, 1'b1);
    chk("reset sources", 8'h06, {5'h0, y4_src, y5_src});
    @(posedge clk);
    rst <= 1'b0;
    settle(6);
    rd(SPO_OFS_MUX_STATE, SPO_RST_MUX_STATE);
    chk("reset setting", 8'h05, {5'h0, active_setting});
    chk("reset amount", 8'h00, spread_amount);
    chk_pair(SPO_ST_HIZ, 1'b1);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : tb_second_pll_output_config
